// *** core/rpio_top.sv ***
// twelve byte-wide i/o ports in four banks, host byte i/o access
`timescale 1ns/1ns
module rpio_top (
    input  wire logic                 mclk,
    input  wire logic                 reset,
    input  wire logic                 clk_en,
    input  wire rpio_pkg::rpio_req_t  io_req,
    output logic [7:0]                io_rdata_q,
    output logic                      io_rvalid_q,
    input  wire rpio_pkg::rpio_lines_t line_in,
    output rpio_pkg::rpio_lines_t     line_out_q,
    output rpio_pkg::rpio_lines_t     line_oe_q,
    output logic                      irq_src_q
);
    import rpio_pkg::*;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    logic [1:0] req_bank;
    logic [2:0] req_sel;
    logic       hit_port;
    logic       hit_dir;
    logic [3:0] rd_idx;

    assign req_bank = io_req.addr[4:3];
    assign req_sel  = io_req.addr[2:0];
    assign hit_port = (req_sel == RPIO_FIRST_OFS) || (req_sel == RPIO_SECOND_OFS)
                   || (req_sel == RPIO_THIRD_OFS);
    assign hit_dir  = (req_sel == RPIO_DIR_OFS);
    assign rd_idx   = 4'(req_bank * RPIO_PORTS_PER_BANK) + 4'(req_sel);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [RPIO_BANKS-1:0][7:0] dir_q;
    logic [RPIO_BANKS-1:0][7:0] dir_d;
    rpio_lines_t                out_d;
    rpio_lines_t                oe_d;
    rpio_lines_t                port_val;
    logic [RPIO_PORTS-1:0]      port_is_out;

    genvar gb;
    genvar gp;
    generate
        for (gb = 0; gb < RPIO_BANKS; gb++) begin : g_bank
            // bank gb answers to the direction word at offset 3 of its own bank
            assign dir_d[gb] = (io_req.wr && hit_dir && req_bank == 2'(gb))
                             ? io_req.wdata : dir_q[gb];
            // only bits 0,1,3,4 are decoded; the rest are stored but inert
            assign oe_d[gb*3+0] = {8{~dir_d[gb][FIRST_PORT_DIR_BIT]}};
            assign oe_d[gb*3+1] = {8{~dir_d[gb][SECOND_PORT_DIR_BIT]}};
            assign oe_d[gb*3+2] = {8{~dir_d[gb][THIRD_PORT_DIR_HIGH_BIT]
                                   & ~dir_d[gb][THIRD_PORT_DIR_LOW_BIT]}};
            for (gp = 0; gp < RPIO_PORTS_PER_BANK; gp++) begin : g_port
                localparam int P = gb * RPIO_PORTS_PER_BANK + gp;
                localparam logic [RPIO_ADDR_W-1:0] OFS =
                    RPIO_ADDR_W'(gb * RPIO_BANK_STRIDE + gp);
                // register written regardless of direction so it can be preset
                assign out_d[P] = (io_req.wr && io_req.addr == OFS)
                                ? io_req.wdata : line_out_q[P];
                assign port_is_out[P] = line_oe_q[P][0];
                assign port_val[P] = port_is_out[P] ? line_out_q[P]
                                                    : line_in[P];
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // read selection
    // ------------------------------------------------------------
    logic [7:0] rd_d;

    assign rd_d = !io_req.rd ? RPIO_OUT_RESET
                : hit_port   ? port_val[rd_idx]
                : hit_dir    ? dir_q[req_bank]
                : 8'h00;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // drivers follow dir_d so a direction write shows one cycle later,
    // and the preset value is already on line_out_q: no glitch level
    always_ff @(posedge mclk) begin
        if (reset) begin
            dir_q      <= {RPIO_BANKS{RPIO_DIR_RESET}};
            line_oe_q  <= '0;
            line_out_q <= {RPIO_PORTS{RPIO_OUT_RESET}};
        end else if (clk_en) begin
            dir_q      <= dir_d;
            line_oe_q  <= oe_d;
            line_out_q <= out_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            io_rdata_q  <= 8'h00;
            io_rvalid_q <= 1'b0;
            irq_src_q   <= 1'b0;
        end else if (clk_en) begin
            io_rdata_q  <= rd_d;
            io_rvalid_q <= io_req.rd;
            irq_src_q   <= port_val[0][0];
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    // reset itself disables the checks, so look at the first edge after release
    chk_reset_inputs: assert property (@(posedge mclk) $fell(reset) |-> line_oe_q == '0)
        else $error("ports not all inputs after reset");
    chk_first_dir: assert property (
        line_oe_q[3] == {8{~dir_q[1][FIRST_PORT_DIR_BIT]}}
        && line_oe_q[4] == {8{~dir_q[1][SECOND_PORT_DIR_BIT]}})
        else $error("first or second port direction wrong");
    chk_third_dir: assert property (
        line_oe_q[2] == {8{dir_q[0][3:0] ==? 4'b0??0}})
        else $error("third port direction wrong");
    chk_dir_latency: assert property (
        clk_en && io_req.wr && io_req.addr == BANK1_DIRECTION_WORD
        |=> line_oe_q[0] == {8{~$past(io_req.wdata[FIRST_PORT_DIR_BIT])}})
        else $error("direction write not applied next cycle");
    chk_inert_bits: assert property (
        clk_en && io_req.wr && io_req.addr == BANK2_DIRECTION_WORD
        && ((io_req.wdata ^ dir_q[1]) & RPIO_DIR_ACTIVE_MASK) == 8'h00
        |=> $stable(line_oe_q))
        else $error("inert direction bit changed a driver");
    chk_preset_out: assert property (
        clk_en && io_req.wr && io_req.addr == BANK1_SECOND_BYTE && !line_oe_q[1][0]
        |=> line_out_q[1] == $past(io_req.wdata))
        else $error("preset write to input port lost");
    chk_read_input: assert property (
        clk_en && io_req.rd && io_req.addr == BANK4_THIRD_BYTE && !line_oe_q[11][0]
        |=> io_rvalid_q && io_rdata_q == $past(line_in[11]))
        else $error("input read not live level");
    chk_read_output: assert property (
        clk_en && io_req.rd && !io_req.wr && io_req.addr == BANK3_FIRST_BYTE
        && line_oe_q[6][0]
        |=> io_rdata_q == $past(line_out_q[6]))
        else $error("output read not driven value");
    chk_irq_source: assert property (
        clk_en && !line_oe_q[0][0] |=> irq_src_q == $past(line_in[0][0]))
        else $error("interrupt source not bank one line zero");

    cov_preset_then_out: cover property (
        io_req.wr && io_req.addr == BANK1_FIRST_BYTE && !line_oe_q[0][0]
        ##[1:20] $rose(line_oe_q[0][0]));
    cov_third_out: cover property ($rose(line_oe_q[11][0]));
    cov_read_dir: cover property (clk_en && io_req.rd && hit_dir);

endmodule

// *** core/rpio_pkg.sv ***
// constants and carrier types for the banked parallel i/o ports
//
// Behaviour
// - Four banks of three byte ports; bank k uses the direction word at 8*(k-1)+3.
// - Each port changes direction as a whole byte, never per line.
// - Word bit 4 sets first port, bit 1 second port; 1 input.
// - Third port is output only when word bits 3 and 0 are both zero.
// - After reset bits 0,1,3,4 are set: all twelve ports are inputs.
// - Word bits 2,5,6 have no effect; software writes bit 7 as one.
// - Every port owns an output register written whatever its direction.
// - Value preset while input is driven at once when switched to output.
// - Line 0 of bank one's first port is the device interrupt source.
// - Port bytes sit at offsets 8*(k-1)+0,1,2 from the i/o base.
// - Reading an input port returns live line levels, active high.
// - Reading an output port returns the register driving the lines.
// - Outputs are active high: a stored one drives the line high.
package rpio_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int RPIO_BANKS          = 4;
    localparam int RPIO_PORTS_PER_BANK = 3;
    localparam int RPIO_PORTS          = RPIO_BANKS * RPIO_PORTS_PER_BANK;
    localparam int RPIO_ADDR_W         = 5;

    // ------------------------------------------------------------
    // byte offsets from the i/o base
    // ------------------------------------------------------------
    localparam logic [RPIO_ADDR_W-1:0] RPIO_BANK_STRIDE = 5'h08;
    localparam logic [2:0] RPIO_FIRST_OFS  = 3'h0;
    localparam logic [2:0] RPIO_SECOND_OFS = 3'h1;
    localparam logic [2:0] RPIO_THIRD_OFS  = 3'h2;
    localparam logic [2:0] RPIO_DIR_OFS    = 3'h3;

    localparam logic [RPIO_ADDR_W-1:0] BANK1_FIRST_BYTE     = 5'h00;
    localparam logic [RPIO_ADDR_W-1:0] BANK1_SECOND_BYTE    = 5'h01;
    localparam logic [RPIO_ADDR_W-1:0] BANK1_THIRD_BYTE     = 5'h02;
    localparam logic [RPIO_ADDR_W-1:0] BANK1_DIRECTION_WORD = 5'h03;
    localparam logic [RPIO_ADDR_W-1:0] BANK2_FIRST_BYTE     = 5'h08;
    localparam logic [RPIO_ADDR_W-1:0] BANK2_SECOND_BYTE    = 5'h09;
    localparam logic [RPIO_ADDR_W-1:0] BANK2_THIRD_BYTE     = 5'h0A;
    localparam logic [RPIO_ADDR_W-1:0] BANK2_DIRECTION_WORD = 5'h0B;
    localparam logic [RPIO_ADDR_W-1:0] BANK3_FIRST_BYTE     = 5'h10;
    localparam logic [RPIO_ADDR_W-1:0] BANK3_SECOND_BYTE    = 5'h11;
    localparam logic [RPIO_ADDR_W-1:0] BANK3_THIRD_BYTE     = 5'h12;
    localparam logic [RPIO_ADDR_W-1:0] BANK3_DIRECTION_WORD = 5'h13;
    localparam logic [RPIO_ADDR_W-1:0] BANK4_FIRST_BYTE     = 5'h18;
    localparam logic [RPIO_ADDR_W-1:0] BANK4_SECOND_BYTE    = 5'h19;
    localparam logic [RPIO_ADDR_W-1:0] BANK4_THIRD_BYTE     = 5'h1A;
    localparam logic [RPIO_ADDR_W-1:0] BANK4_DIRECTION_WORD = 5'h1B;

    // ------------------------------------------------------------
    // direction word fields
    // ------------------------------------------------------------
    localparam int THIRD_PORT_DIR_LOW_BIT  = 0;
    localparam int SECOND_PORT_DIR_BIT     = 1;
    localparam int UNUSED_BIT_TWO          = 2;
    localparam int THIRD_PORT_DIR_HIGH_BIT = 3;
    localparam int FIRST_PORT_DIR_BIT      = 4;
    localparam int UNUSED_BIT_FIVE         = 5;
    localparam int UNUSED_BIT_SIX          = 6;
    localparam int FIXED_ONE_BIT           = 7;
    localparam logic [7:0] RPIO_DIR_ACTIVE_MASK = 8'h1B;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RPIO_DIR_RESET = 8'h9B;
    localparam logic [7:0] RPIO_OUT_RESET = 8'h00;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic                   wr;
        logic                   rd;
        logic [RPIO_ADDR_W-1:0] addr;
        logic [7:0]             wdata;
    } rpio_req_t;

    typedef logic [RPIO_PORTS-1:0][7:0] rpio_lines_t;

endpackage

// *** bench/rpio_field_model.sv ***
// field wiring model: outside drivers, bussed pull-ups and the board's own drivers
`timescale 1ns/1ns
module rpio_field_model (
    input  wire logic [rpio_pkg::RPIO_PORTS-1:0] ext_drv,
    input  wire rpio_pkg::rpio_lines_t           ext_val,
    input  wire rpio_pkg::rpio_lines_t           line_out_q,
    input  wire rpio_pkg::rpio_lines_t           line_oe_q,
    output rpio_pkg::rpio_lines_t                line_in
);
    import rpio_pkg::*;
    // ------------------------------------------------------------
    // line levels
    // ------------------------------------------------------------
    // a released line floats up to one through the pull-up, never holds its old level
    for (genvar p = 0; p < RPIO_PORTS; p++) begin : g_line
        assign line_in[p] = (line_oe_q[p] & line_out_q[p])
                          | (~line_oe_q[p] & (ext_drv[p] ? ext_val[p] : 8'hFF));
    end
endmodule

// *** bench/rpio_top_tb.sv ***
// self-checking bench for the banked parallel i/o ports
`timescale 1ns/1ns
module rpio_top_tb;
    import rpio_pkg::*;
    logic                  mclk, reset, clk_en, io_rvalid_q, irq_src_q;
    rpio_req_t             io_req;
    logic [7:0]            io_rdata_q;
    rpio_lines_t           line_in, line_out_q, line_oe_q, ext_val;
    logic [RPIO_PORTS-1:0] ext_drv;
    int                    err_total, check_count;
    rpio_top dut (.mclk(mclk), .reset(reset), .clk_en(clk_en), .io_req(io_req), .io_rdata_q(io_rdata_q),
        .io_rvalid_q(io_rvalid_q), .line_in(line_in), .line_out_q(line_out_q), .line_oe_q(line_oe_q),
        .irq_src_q(irq_src_q));
    rpio_field_model fld (.ext_drv(ext_drv), .ext_val(ext_val), .line_out_q(line_out_q),
        .line_oe_q(line_oe_q), .line_in(line_in));
    // ------------------------------------------------------------
    // bus and compare helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [95:0] exp, input logic [95:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(negedge mclk);
        io_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge mclk);
        io_req = '0;
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
        @(negedge mclk);
        io_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge mclk);
        io_req = '0;
        chk("rdata", {88'h0, exp}, {88'h0, io_rdata_q});
        chk("rvalid", 96'h1, {95'h0, io_rvalid_q});
    endtask
    function automatic logic [7:0] oe_exp(input logic [7:0] w, input int port);
        case (port)
            0: return {8{~w[FIRST_PORT_DIR_BIT]}};
            1: return {8{~w[SECOND_PORT_DIR_BIT]}};
            default: return {8{~(w[THIRD_PORT_DIR_HIGH_BIT] | w[THIRD_PORT_DIR_LOW_BIT])}};
        endcase
    endfunction
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        for (int b = 0; b < 4; b++) rd_chk(5'(b * 8 + 3), RPIO_DIR_RESET);
        chk("oe after reset", 96'h0, line_oe_q);
    endtask
    task automatic t_dir();
        logic [7:0] words [6] = '{8'h80, 8'h90, 8'h82, 8'h88, 8'h81, 8'hE4};
        for (int b = 0; b < 4; b++) begin
            foreach (words[i]) begin
                wr(5'(b * 8 + 3), words[i]);
                for (int p = 0; p < 3; p++) chk("oe", {88'h0, oe_exp(words[i], p)}, {88'h0, line_oe_q[b*3+p]});
            end
            wr(5'(b * 8 + 3), RPIO_DIR_RESET);
        end
        chk("out regs untouched", 96'h0, line_out_q);
    endtask
    task automatic t_preset();
        logic [7:0] v;
        for (int p = 0; p < RPIO_PORTS; p++) begin
            v = {4'(p), ~4'(p)};
            wr(5'((p / 3) * 8 + p % 3), v);
            chk("preset oe", 96'h0, {88'h0, line_oe_q[p]});
            chk("preset value", {88'h0, v}, {88'h0, line_out_q[p]});
        end
        for (int b = 0; b < 4; b++) wr(5'(b * 8 + 3), 8'h80);
        for (int p = 0; p < RPIO_PORTS; p++) begin
            v = {4'(p), ~4'(p)};
            chk("driven at switch", {88'h0, v}, {88'h0, line_out_q[p]});
            rd_chk(5'((p / 3) * 8 + p % 3), v);
        end
        for (int b = 0; b < 4; b++) wr(5'(b * 8 + 3), RPIO_DIR_RESET);
        chk("kept across switch", {4'hB, 4'h4, 8'hA5, 8'h96, 8'h87, 8'h78, 8'h69, 8'h5A, 8'h4B, 8'h3C, 8'h2D, 8'h1E, 8'h0F}, {4'hB, 4'h4, line_out_q});
    endtask
    task automatic t_input();
        @(negedge mclk);
        ext_drv = '1;
        for (int p = 0; p < RPIO_PORTS; p++) ext_val[p] = 8'hA4 ^ 8'(p);
        for (int p = 0; p < RPIO_PORTS; p++) rd_chk(5'((p / 3) * 8 + p % 3), 8'hA4 ^ 8'(p));
        chk("irq low", 96'h0, {95'h0, irq_src_q});
        ext_val[0] = 8'h01;
        repeat (2) @(negedge mclk);
        chk("irq high", 96'h1, {95'h0, irq_src_q});
        ext_drv = '0;
        rd_chk(5'h09, 8'hFF);
        rd_chk(5'h04, 8'h00);
    endtask
    task automatic t_hold();
        wr(BANK2_DIRECTION_WORD, 8'h1F);
        chk("inert oe", 96'h0, line_oe_q);
        wr(BANK1_FIRST_BYTE, 8'h3C);
        @(negedge mclk);
        clk_en = 1'b0;
        io_req = '{wr: 1'b1, rd: 1'b0, addr: BANK1_DIRECTION_WORD, wdata: 8'h80};
        repeat (2) @(negedge mclk);
        chk("frozen oe", 96'h0, line_oe_q);
        io_req = '0;
        clk_en = 1'b1;
        rd_chk(BANK2_DIRECTION_WORD, 8'h1F);
        wr(BANK1_DIRECTION_WORD, 8'h80);
        chk("oe bank one", 96'hFF_FFFF, {72'h0, line_oe_q[2], line_oe_q[1], line_oe_q[0]});
        chk("preset bank one", 96'h3C, {88'h0, line_out_q[0]});
        @(negedge mclk);
        reset = 1'b1;
        @(negedge mclk);
        reset = 1'b0;
        chk("oe after second reset", 96'h0, line_oe_q);
        chk("out after second reset", 96'h0, line_out_q);
        rd_chk(BANK1_DIRECTION_WORD, RPIO_DIR_RESET);
    endtask
    task automatic summarize();
        if (err_total == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    initial begin
        reset = 1'b1;
        clk_en = 1'b1;
        io_req = '0;
        ext_drv = '0;
        ext_val = '0;
        err_total = 0;
        check_count = 0;
        repeat (5) @(negedge mclk);
        reset = 1'b0;
        t_reset();
        t_dir();
        t_preset();
        t_input();
        t_hold();
        summarize();
    end
endmodule
